// ===== ssa_alu.v
`timescale 1ns/1ps
`include "ssa_alu_regs.vh"

module ssa_alu #(
	parameter OP_W = `SSA_OP_W
) (
	input  wire            mclk,
	input  wire            rst_b,
	input  wire            op_valid,
	input  wire [OP_W-1:0] op_code,
	input  wire            cond_pass,
	input  wire [31:0]     first_operand,
	input  wire [31:0]     second_operand,
	input  wire            status_wr_en,
	input  wire            status_wr_sat,
	output reg             result_valid_r,
	output reg  [31:0]     result_r,
	output reg             sat_flag_r
);

	// Signed byte add or subtract; bit 8 reports a clamp.
	// One guard bit holds the exact result, so a clamp is needed just
	// when the guard bit and the sign bit disagree.
	function [8:0] ssat8;
		input [7:0] a;
		input [7:0] b;
		input       sub;
		reg   [8:0] s;
		begin
			s = sub ? ({a[7], a} - {b[7], b}) : ({a[7], a} + {b[7], b});
			if (s[8] != s[7]) begin
				ssat8 = {1'b1, s[8] ? 8'h80 : 8'h7f};
			end else begin
				ssat8 = {1'b0, s[7:0]};
			end
		end
	endfunction

	// Signed halfword add or subtract; bit 16 reports a clamp.
	// It uses the same guard-bit test as the byte case, one lane wider.
	function [16:0] ssat16;
		input [15:0] a;
		input [15:0] b;
		input        sub;
		reg   [16:0] s;
		begin
			s = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
			if (s[16] != s[15]) begin
				ssat16 = {1'b1, s[16] ? 16'h8000 : 16'h7fff};
			end else begin
				ssat16 = {1'b0, s[15:0]};
			end
		end
	endfunction

	// Signed word add or subtract; bit 32 reports a clamp.
	// The word version also feeds the doubling step, where the clamp bit
	// is what later sets the sticky flag.
	function [32:0] ssat32;
		input [31:0] a;
		input [31:0] b;
		input        sub;
		reg   [32:0] s;
		begin
			s = sub ? ({a[31], a} - {b[31], b}) : ({a[31], a} + {b[31], b});
			if (s[32] != s[31]) begin
				ssat32 = {1'b1, s[32] ? 32'h8000_0000 : 32'h7fff_ffff};
			end else begin
				ssat32 = {1'b0, s[31:0]};
			end
		end
	endfunction

	// Unsigned byte add or subtract, clamped to 0..255.
	// A borrow out of a subtract means the true value fell below zero,
	// and a carry out of an add means it passed the top of the range.
	function [7:0] usat8;
		input [7:0] a;
		input [7:0] b;
		input       sub;
		reg   [8:0] s;
		begin
			s = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
			if (s[8]) begin
				usat8 = sub ? 8'h00 : 8'hff;
			end else begin
				usat8 = s[7:0];
			end
		end
	endfunction

	// Unsigned halfword add or subtract, clamped to 0..65535.
	// It uses the same carry or borrow test as the byte case.
	function [15:0] usat16;
		input [15:0] a;
		input [15:0] b;
		input        sub;
		reg   [16:0] s;
		begin
			s = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
			if (s[16]) begin
				usat16 = sub ? 16'h0000 : 16'hffff;
			end else begin
				usat16 = s[15:0];
			end
		end
	endfunction

	reg  [31:0] result_nxt;
	reg         sat_set;
	wire [15:0] a_hi = first_operand[31:16];
	wire [15:0] a_lo = first_operand[15:0];
	wire [15:0] b_hi = second_operand[31:16];
	wire [15:0] b_lo = second_operand[15:0];
	wire        is_sub_op;
	wire        exec;
	wire [32:0] word_res;
	wire [32:0] dbl_val;
	wire [32:0] dbl_res;
	wire [16:0] xs_top;
	wire [16:0] xs_bot;
	wire [15:0] xu_top;
	wire [15:0] xu_bot;
	wire [31:0] bytes_s;
	wire [31:0] bytes_u;
	wire [31:0] halves_s;
	wire [31:0] halves_u;
	wire        flag_set;
	genvar      g;

	// Subtracting lane opcodes, shared by the lane loops below.
	// Only the lane codes need it; the exchange codes pick per half.
	assign is_sub_op = (op_code == `SSA_OP_SUB_BYTES_S) ||
		(op_code == `SSA_OP_SUB_HALVES_S) ||
		(op_code == `SSA_OP_SUB_BYTES_U) ||
		(op_code == `SSA_OP_SUB_HALVES_U);

	// An operation runs only when its condition holds.
	assign exec = op_valid & cond_pass;

	// Word add or subtract; bit 32 reports the clamp.
	assign word_res = ssat32(first_operand, second_operand,
		op_code == `SSA_OP_SUB_WORD);

	// Doubling saturates on its own first, so a large second operand
	// reaches the final add or subtract already clamped.
	assign dbl_val = ssat32(second_operand, second_operand, 1'b0);
	assign dbl_res = ssat32(first_operand, dbl_val[31:0],
		op_code == `SSA_OP_DOUBLE_SUB);

	// Signed exchange: each half adds for one code and subtracts for the
	// other; these clamps never reach the sticky flag.
	assign xs_top = ssat16(a_hi, b_lo,
		op_code == `SSA_OP_SUB_ADD_X_S);
	assign xs_bot = ssat16(a_lo, b_hi,
		op_code != `SSA_OP_SUB_ADD_X_S);

	// Unsigned exchange with the same crossing of halves.
	assign xu_top = usat16(a_hi, b_lo,
		op_code == `SSA_OP_SUB_ADD_X_U);
	assign xu_bot = usat16(a_lo, b_hi,
		op_code != `SSA_OP_SUB_ADD_X_U);

	// A clamp counts toward the flag only when the operation executes.
	assign flag_set = exec & sat_set;

	// Signed byte lanes, each clamped on its own; no carry crosses a lane.
	generate
		for (g = 0; g < `SSA_BYTE_LANES; g = g + 1) begin : g_byte
			localparam integer LANE_LO = g * `SSA_BYTE_W;
			wire [7:0] a_lane = first_operand[LANE_LO +: `SSA_BYTE_W];
			wire [7:0] b_lane = second_operand[LANE_LO +: `SSA_BYTE_W];
			wire [8:0] s_lane = ssat8(a_lane, b_lane, is_sub_op);
			// The lane clamp bit is left unread: lanes keep the flag.
			assign bytes_s[LANE_LO +: `SSA_BYTE_W] =
				s_lane[7:0];
		end
	endgenerate

	// Unsigned byte lanes: a carry clamps to all ones, a borrow to zero.
	generate
		for (g = 0; g < `SSA_BYTE_LANES; g = g + 1) begin : g_ubyte
			localparam integer LANE_LO = g * `SSA_BYTE_W;
			wire [7:0] a_lane = first_operand[LANE_LO +: `SSA_BYTE_W];
			wire [7:0] b_lane = second_operand[LANE_LO +: `SSA_BYTE_W];
			assign bytes_u[LANE_LO +: `SSA_BYTE_W] =
				usat8(a_lane, b_lane, is_sub_op);
		end
	endgenerate

	// Signed halfword lanes, built the same way as the byte lanes.
	generate
		for (g = 0; g < `SSA_HALF_LANES; g = g + 1) begin : g_half
			localparam integer LANE_LO = g * `SSA_HALF_W;
			wire [15:0] a_lane = first_operand[LANE_LO +: `SSA_HALF_W];
			wire [15:0] b_lane = second_operand[LANE_LO +: `SSA_HALF_W];
			wire [16:0] s_lane = ssat16(a_lane, b_lane, is_sub_op);
			// Halfword lane clamps are likewise kept away from the flag.
			assign halves_s[LANE_LO +: `SSA_HALF_W] =
				s_lane[15:0];
		end
	endgenerate

	// Unsigned halfword lanes, clamped to the unsigned halfword range.
	generate
		for (g = 0; g < `SSA_HALF_LANES; g = g + 1) begin : g_uhalf
			localparam integer LANE_LO = g * `SSA_HALF_W;
			wire [15:0] a_lane = first_operand[LANE_LO +: `SSA_HALF_W];
			wire [15:0] b_lane = second_operand[LANE_LO +: `SSA_HALF_W];
			assign halves_u[LANE_LO +: `SSA_HALF_W] =
				usat16(a_lane, b_lane, is_sub_op);
		end
	endgenerate

	// Result select and clamp report for the presented operation code.
	always @* begin
		result_nxt = `SSA_RESULT_RST;
		sat_set    = 1'b0;
		case (op_code)
		`SSA_OP_ADD_WORD, `SSA_OP_SUB_WORD: begin
			result_nxt = word_res[31:0];
			sat_set    = word_res[32];
		end
		`SSA_OP_ADD_BYTES_S, `SSA_OP_SUB_BYTES_S: begin
			result_nxt = bytes_s;
		end
		`SSA_OP_ADD_HALVES_S, `SSA_OP_SUB_HALVES_S: begin
			result_nxt = halves_s;
		end
		`SSA_OP_ADD_SUB_X_S, `SSA_OP_SUB_ADD_X_S: begin
			result_nxt = {xs_top[15:0], xs_bot[15:0]};
		end
		`SSA_OP_DOUBLE_ADD, `SSA_OP_DOUBLE_SUB: begin
			result_nxt = dbl_res[31:0];
			sat_set    = dbl_val[32] | dbl_res[32];
		end
		`SSA_OP_ADD_SUB_X_U, `SSA_OP_SUB_ADD_X_U: begin
			result_nxt = {xu_top, xu_bot};
		end
		`SSA_OP_ADD_BYTES_U, `SSA_OP_SUB_BYTES_U: begin
			result_nxt = bytes_u;
		end
		`SSA_OP_ADD_HALVES_U, `SSA_OP_SUB_HALVES_U: begin
			result_nxt = halves_u;
		end
		default: begin
			result_nxt = `SSA_RESULT_RST;
		end
		endcase
	end

	// Result register and valid strobe; result holds when not executed.
	// The valid strobe stands for one cycle per executed operation.
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			result_valid_r <= 1'b0;
			result_r       <= `SSA_RESULT_RST;
		end else begin
			result_valid_r <= exec;
			if (exec) begin
				result_r <= result_nxt;
			end
		end
	end

	// Sticky flag: an explicit write loads it, a clamp sets it and wins.
	// No arithmetic path ever clears it; only the status write can.
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sat_flag_r <= `SSA_FLAG_RST;
		end else if (status_wr_en || flag_set) begin
			sat_flag_r <= (status_wr_en ? status_wr_sat : sat_flag_r) |
				flag_set;
		end
	end

endmodule // ssa_alu

// ===== ssa_alu_monitor.sv
`timescale 1ns/1ps
module ssa_alu_monitor (
	input wire        mclk,
	input wire        rst_b,
	input wire        op_valid,
	input wire [3:0]  op_code,
	input wire        cond_pass,
	input wire [31:0] first_operand,
	input wire [31:0] second_operand,
	input wire        status_wr_en,
	input wire        status_wr_sat,
	input wire        result_valid_r,
	input wire [31:0] result_r,
	input wire        sat_flag_r
);
	// Executed op, ops that may set the flag, low byte sum, word sum and difference.
	wire        go = op_valid && cond_pass;
	wire        wset = go && (op_code == 4'h0 || op_code == 4'h3
		|| op_code[3:1] == 3'h4);
	wire [8:0]  ub = first_operand[7:0] + second_operand[7:0];
	wire [31:0] ws = first_operand + second_operand;
	wire [31:0] wd = first_operand - second_operand;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_result_follows_op: assert property (go |=> result_valid_r)
		else $error("no result after executed op");
	a_refused_op_quiet: assert property (!go |=> !result_valid_r
		&& $stable(result_r)) else $error("refused op changed result");
	a_word_add_clamp: assert property (go && op_code == 4'h0
		&& !first_operand[31] && !second_operand[31] && ws[31]
		|=> result_r == 32'h7fffffff && sat_flag_r)
		else $error("word add not clamped to maximum");
	a_word_sub_clamp: assert property (go && op_code == 4'h3
		&& first_operand[31] && !second_operand[31] && !wd[31]
		|=> result_r == 32'h80000000) else $error("word sub not clamped");
	a_flag_stays_set: assert property (sat_flag_r && !status_wr_en
		|=> sat_flag_r) else $error("sticky flag cleared by op");
	a_lane_flag_held: assert property (go && !wset && !status_wr_en
		|=> $stable(sat_flag_r)) else $error("lane op changed flag");
	a_flag_write_lands: assert property (status_wr_en && !wset
		|=> sat_flag_r == $past(status_wr_sat)) else $error("flag write lost");
	a_ubyte_add_clamp: assert property (go && op_code == 4'hc
		|=> result_r[7:0] == ($past(ub[8]) ? 8'hff : $past(ub[7:0])))
		else $error("unsigned byte sum wrong");
	a_ubyte_sub_zero: assert property (go && op_code == 4'he
		&& first_operand[7:0] < second_operand[7:0] |=> result_r[7:0] == 8'h00)
		else $error("unsigned byte difference not zero");
	a_double_flag_set: assert property (go && op_code[3:1] == 3'h4
		&& second_operand[31:30] == 2'b01 |=> sat_flag_r)
		else $error("doubling clamp did not set flag");
endmodule // ssa_alu_monitor
bind ssa_alu ssa_alu_monitor i_mon (
	.mclk           (mclk),
	.rst_b          (rst_b),
	.op_valid       (op_valid),
	.op_code        (op_code),
	.cond_pass      (cond_pass),
	.first_operand  (first_operand),
	.second_operand (second_operand),
	.status_wr_en   (status_wr_en),
	.status_wr_sat  (status_wr_sat),
	.result_valid_r (result_valid_r),
	.result_r       (result_r),
	.sat_flag_r     (sat_flag_r)
);

// ===== ssa_alu_regs.vh
`ifndef SSA_ALU_REGS_VH
`define SSA_ALU_REGS_VH

// Operation select codes presented on op_code.
`define SSA_OP_W                 4
`define SSA_OP_ADD_WORD          4'h0
`define SSA_OP_ADD_BYTES_S       4'h1
`define SSA_OP_ADD_HALVES_S      4'h2
`define SSA_OP_SUB_WORD          4'h3
`define SSA_OP_SUB_BYTES_S       4'h4
`define SSA_OP_SUB_HALVES_S      4'h5
`define SSA_OP_ADD_SUB_X_S       4'h6
`define SSA_OP_SUB_ADD_X_S       4'h7
`define SSA_OP_DOUBLE_ADD        4'h8
`define SSA_OP_DOUBLE_SUB        4'h9
`define SSA_OP_ADD_SUB_X_U       4'ha
`define SSA_OP_SUB_ADD_X_U       4'hb
`define SSA_OP_ADD_BYTES_U       4'hc
`define SSA_OP_ADD_HALVES_U      4'hd
`define SSA_OP_SUB_BYTES_U       4'he
`define SSA_OP_SUB_HALVES_U      4'hf

// Lane geometry.
`define SSA_BYTE_W               8
`define SSA_HALF_W               16
`define SSA_WORD_W               32
`define SSA_BYTE_LANES           4
`define SSA_HALF_LANES           2

// Reset values.
`define SSA_RESULT_RST           32'h0000_0000
`define SSA_FLAG_RST             1'b0

`endif

// ===== ssa_rf_model.sv
`timescale 1ns/1ps
module ssa_rf_model (
	input  wire        mclk,
	output reg         op_valid,
	output reg  [3:0]  op_code,
	output reg         cond_pass,
	output reg  [31:0] first_operand,
	output reg  [31:0] second_operand,
	output reg         status_wr_en,
	output reg         status_wr_sat
);
	// Requests hold still from one edge to the next; idle at time zero.
	initial begin
		drive(0, 0, 0, 0, 0, 0, 0);
	end
	// Operand values only, never register numbers, are presented.
	task automatic drive(input logic v, c, input logic [3:0] o,
		input logic [31:0] a, b, input logic we, wv);
		begin
		op_valid = v;
		cond_pass = c;
		op_code = o;
		first_operand = a;
		second_operand = b;
		status_wr_en = we;
		status_wr_sat = wv;
		if ($time > 0) begin
			@(posedge mclk);
			#1;
		end
		end
	endtask
endmodule // ssa_rf_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
	reg         mclk = 1'b0;
	reg         rst_b = 1'b0;
	wire        ov, cp, we, wv, rv, fl;
	wire [3:0]  oc;
	wire [31:0] fa, sb, res;
	integer     bad_count = 0;
	integer     tests_run = 0;
	integer     cyc = 0;
	logic [31:0] ta [4] = '{32'h7fff7f7f, 32'h80008080, 32'h00ff0001,
		32'hc0000000};
	logic [31:0] tb_v [4] = '{32'h00010101, 32'h00010101, 32'hff01ff02,
		32'h40000000};
	ssa_rf_model i_rf (.mclk(mclk), .op_valid(ov), .op_code(oc),
		.cond_pass(cp), .first_operand(fa), .second_operand(sb),
		.status_wr_en(we), .status_wr_sat(wv));
	ssa_alu i_dut (.mclk(mclk), .rst_b(rst_b), .op_valid(ov), .op_code(oc),
		.cond_pass(cp), .first_operand(fa), .second_operand(sb),
		.status_wr_en(we), .status_wr_sat(wv), .result_valid_r(rv),
		.result_r(res), .sat_flag_r(fl));
	// Lane extraction and clamping for the reference model.
	function automatic longint ext(input [31:0] x, input int n, i, u);
		longint t;
		t = (x >> (n * i)) & ((64'sh1 << n) - 1);
		if (!u && t[n-1]) t = t - (64'sh1 << n);
		return t;
	endfunction
	function automatic longint cl(input longint v, input int n, u);
		longint hi, lo;
		hi = u ? (64'sh1 << n) - 1 : (64'sh1 << (n - 1)) - 1;
		lo = u ? 0 : -(64'sh1 << (n - 1));
		return v > hi ? hi : (v < lo ? lo : v);
	endfunction
	// Expected clamp flag and result of one operation.
	function automatic [32:0] ref_op(input [3:0] op, input [31:0] a, b);
		int n, u, s, i;
		longint x, y, d;
		logic [31:0] r;
		logic q;
		n = (op == 1 || op == 4 || (op >= 12 && !op[0])) ? 8 : 16;
		u = op >= 10;
		s = op == 4 || op == 5 || op >= 14;
		r = 0;
		q = 0;
		if (op == 0 || op == 3 || op[3:1] == 4) begin
			x = ext(a, 32, 0, 0);
			y = ext(b, 32, 0, 0);
			if (op >= 8) begin
				d = cl(2 * y, 32, 0);
				q = d != 2 * y;
				y = d;
			end
			d = op[0] ? x - y : x + y;
			x = cl(d, 32, 0);
			q = q || x != d;
			r = 32'(x);
		end else if (op[3:1] == 3 || op[3:1] == 5) begin
			x = ext(a, 16, 1, u) + (op[0] ? -1 : 1) * ext(b, 16, 0, u);
			y = ext(a, 16, 0, u) - (op[0] ? -1 : 1) * ext(b, 16, 1, u);
			r = {16'(cl(x, 16, u)), 16'(cl(y, 16, u))};
		end else begin
			for (i = 0; i < 32 / n; i++) begin
				x = ext(a, n, i, u);
				y = ext(b, n, i, u);
				d = cl(s ? x - y : x + y, n, u);
				r = r | (32'(d & ((64'sh1 << n) - 1)) << (n * i));
			end
		end
		return {q, r};
	endfunction
	task chk(input [33:0] got, exp);
		begin
		tests_run = tests_run + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
		end
	endtask
	// Word clamp sets the flag; plain and lane results leave it; write clears.
	task t_word;
		begin
		i_rf.drive(1, 1, 0, 32'h7fffffff, 32'h1, 0, 0);
		chk({rv, fl, res}, {2'b11, 32'h7fffffff});
		i_rf.drive(1, 1, 3, 32'h0, 32'h1, 0, 0);
		chk({rv, fl, res}, {2'b11, 32'hffffffff});
		i_rf.drive(1, 1, 1, 32'h7f, 32'h1, 0, 0);
		chk({rv, fl, res}, {2'b11, 32'h7f});
		i_rf.drive(1, 1, 3, 32'h80000000, 32'h1, 1, 0);
		chk({rv, fl, res}, {2'b11, 32'h80000000});
		i_rf.drive(0, 0, 0, 0, 0, 1, 0);
		chk({rv, fl, res}, {2'b00, 32'h80000000});
		end
	endtask
	// A failing condition leaves result, strobe and flag alone.
	task t_cond;
		begin
		i_rf.drive(1, 0, 0, 32'h7fffffff, 32'h1, 0, 0);
		chk({rv, fl, res}, {2'b00, 32'h80000000});
		end
	endtask
	// All codes back to back over the operand table, flag cleared alongside.
	task t_all_ops;
		logic [32:0] e;
		int o, p;
		begin
		for (o = 0; o < 16; o++)
			for (p = 0; p < 4; p++) begin
				e = ref_op(o[3:0], ta[p], tb_v[p]);
				i_rf.drive(1, 1, o[3:0], ta[p], tb_v[p], 1, 0);
				if (o < 6) chk({rv, fl, res}, {1'b1, e});
				else if (o < 12) chk({rv, fl, res}, {1'b1, e});
				else chk({rv, fl, res}, {1'b1, e});
			end
		i_rf.drive(0, 0, 0, 0, 0, 0, 0);
		end
	endtask
	task test_done;
		begin
		if (bad_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
		end
	endtask
	// Free-running clock and a ceiling on the run length.
	initial begin
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count = bad_count + 1;
			test_done;
		end
	end
	// Reset for five cycles, then the scenarios in turn.
	initial begin
		repeat (5) @(posedge mclk);
		#1 rst_b = 1'b1;
		t_word;
		t_cond;
		t_all_ops;
		test_done;
	end
endmodule // testbench
